// ==== include/dsmgc_consts.vh ====
// Summary of operation
// - unimplemented bits ignore writes, read zero
// - stop bit gates module clock off
// - stopped: only config readable, writes still land
// - stop set by reset and host write
// - freeze with freeze bit one halts engine
// - level field picks request line, zero disables
// - equal levels: synchronous request wins
// - contend only when acknowledged level matches
// - serial contention on arbitration number, nonzero
// - vector bits 7:1 from register, bit0 source
// - reset loads vector with 0f
// - vector bit0 writes ignored, reads one
// - assignment bit: clear gpio, set sync engine
// - direction bit: clear input, set output
// - transmit pin forced output while transmitter enabled
// - data register drives outputs, reads pin levels
// - slave select pin behaviour per mode, direction
// - clock pin gpio unless sync engine enabled
`ifndef DSMGC_CONSTS_VH
`define DSMGC_CONSTS_VH

// register word indices
`define DSMGC_IDX_CONFIG     3'h0
`define DSMGC_IDX_LVL_VEC    3'h2
`define DSMGC_IDX_PORT_DATA  3'h3
`define DSMGC_IDX_PAR_DDR    3'h4

// module_config fields
`define DSMGC_CFG_STOP       15
`define DSMGC_CFG_FRZ_HI     14
`define DSMGC_CFG_FRZ_LO     13
`define DSMGC_CFG_ARBITRATION_NUMBER_HI    3

// interrupt_level fields, high byte of the shared word
`define DSMGC_LVL_SYNC_HI    13
`define DSMGC_LVL_SYNC_LO    11
`define DSMGC_LVL_ASYNC_HI   10
`define DSMGC_LVL_ASYNC_LO   8

// reset values
`define DSMGC_RST_STOP       1'b1
`define DSMGC_RST_VECTOR     8'h0f
`define DSMGC_RST_BYTE       8'h00

// pin numbers with special duties
`define DSMGC_PIN_SCK        2
`define DSMGC_PIN_SEL        3
`define DSMGC_PIN_TXD        7

`endif

// ==== hdl/dsmgc_global_ctrl.v ====
`timescale 1ns/1ns
`include "dsmgc_consts.vh"

module dsmgc_global_ctrl #(
	parameter NUM_PINS = 8
) (
	// clock and reset
	input  wire                core_clk,
	input  wire                reset,
	// register port
	input  wire [2:0]          reg_addr,
	input  wire                reg_wr,
	input  wire                reg_rd,
	input  wire [1:0]          reg_byte_en,
	input  wire [15:0]         reg_wdata,
	output reg  [15:0]         reg_rdata_q,
	// stop and freeze
	input  wire                freeze,
	output reg                 module_clk_en_q,
	output reg                 sync_halt_req_q,
	// submodule interrupt sources
	input  wire                sync_irq_flag,
	input  wire                sync_irq_en,
	input  wire                async_irq_flag,
	input  wire                async_irq_en,
	output reg  [7:1]          irq_lines_q,
	// interrupt acknowledge and arbitration
	input  wire                iack_start,
	input  wire [2:0]          iack_level,
	input  wire                arb_bus,
	output reg                 arb_bit_q,
	output reg  [7:0]          vec_data_q,
	output reg                 vec_oe_q,
	// engine side of the pins
	input  wire                sync_engine_enable,
	input  wire                sync_master,
	input  wire [6:0]          sync_out,
	input  wire                transmitter_enable,
	input  wire                tx_data,
	output reg  [NUM_PINS-1:0] pin_level_q,
	output reg                 mode_fault_q,
	output reg                 slave_select_n_q,
	// port pins
	input  wire [NUM_PINS-1:0] pin_in,
	output reg  [NUM_PINS-1:0] pin_out_q,
	output reg  [NUM_PINS-1:0] pin_oe_q
);

	// acknowledge sequencer states
	localparam ST_IDLE = 3'b001;
	localparam ST_ARB  = 3'b010;
	localparam ST_VEC  = 3'b100;
	localparam [7:0] RST_VEC = `DSMGC_RST_VECTOR; // bit 0 is never stored

	// register contents
	reg                stop_q;
	reg  [1:0]         freeze_select_q;
	reg  [3:0]         arbitration_number_q;
	reg  [2:0]         sync_irq_level_q;
	reg  [2:0]         async_irq_level_q;
	reg  [7:1]         vector_field_q;
	reg  [NUM_PINS-1:0] pin_assignment_q;
	reg  [NUM_PINS-1:0] pin_direction_q;
	reg  [NUM_PINS-1:0] port_data_q;

	// acknowledge sequencer
	reg  [2:0]         state_q;
	reg  [1:0]         bit_idx_q;
	reg                src_sync_q;

	// combinational helpers
	reg  [15:0]        rd_d;
	reg  [NUM_PINS-1:0] pin_out_d;
	reg  [NUM_PINS-1:0] pin_oe_d;
	reg                mode_fault_d;
	reg                slave_select_n_d;
	wire               sync_pend;
	wire               async_pend;
	wire               sync_match;
	wire               async_match;
	wire               contend;
	wire               lost;
	integer            i;

	// level field to request line, zero gives no line
	function [7:1] lvl_onehot;
		input [2:0] lvl;
		begin
			lvl_onehot = (lvl == 3'h0) ? 7'h00 : 7'h01 << (lvl - 3'h1);
		end
	endfunction

	// byte merge for writes under byte enables
	function [7:0] merge_byte;
		input       en;
		input [7:0] old_val;
		input [7:0] new_val;
		begin
			merge_byte = en ? new_val : old_val;
		end
	endfunction

	// register writes land in stop too: this clock is ungated
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			stop_q               <= `DSMGC_RST_STOP;
			freeze_select_q      <= 2'h0;
			arbitration_number_q <= 4'h0;
			sync_irq_level_q     <= 3'h0;
			async_irq_level_q    <= 3'h0;
			vector_field_q       <= RST_VEC[7:1];
			pin_assignment_q     <= `DSMGC_RST_BYTE;
			pin_direction_q      <= `DSMGC_RST_BYTE;
			port_data_q          <= `DSMGC_RST_BYTE;
		end
		else if (reg_wr)
		begin
			if (reg_addr == `DSMGC_IDX_CONFIG)
			begin
				if (reg_byte_en[1])
				begin
					stop_q <= reg_wdata[`DSMGC_CFG_STOP];
					freeze_select_q <=
						reg_wdata[`DSMGC_CFG_FRZ_HI:`DSMGC_CFG_FRZ_LO];
				end
				if (reg_byte_en[0])
					arbitration_number_q <=
						reg_wdata[`DSMGC_CFG_ARBITRATION_NUMBER_HI:0];
			end
			else if (reg_addr == `DSMGC_IDX_LVL_VEC)
			begin
				if (reg_byte_en[1])
				begin
					sync_irq_level_q <= reg_wdata[
						`DSMGC_LVL_SYNC_HI:`DSMGC_LVL_SYNC_LO];
					async_irq_level_q <= reg_wdata[
						`DSMGC_LVL_ASYNC_HI:`DSMGC_LVL_ASYNC_LO];
				end
				// bit 0 is not stored at all
				if (reg_byte_en[0])
					vector_field_q <= reg_wdata[7:1];
			end
			else if (reg_addr == `DSMGC_IDX_PORT_DATA)
				port_data_q <= merge_byte(reg_byte_en[0],
					port_data_q, reg_wdata[7:0]);
			else if (reg_addr == `DSMGC_IDX_PAR_DDR)
			begin
				pin_assignment_q <= merge_byte(reg_byte_en[1],
					pin_assignment_q, reg_wdata[15:8]);
				pin_direction_q <= merge_byte(reg_byte_en[0],
					pin_direction_q, reg_wdata[7:0]);
			end
			// other addresses: writes dropped
		end
	end

	// read data; unused bits are zero, only config readable in stop
	always @*
	begin
		rd_d = 16'h0000;
		if (reg_addr == `DSMGC_IDX_CONFIG)
		begin
			rd_d[`DSMGC_CFG_STOP] = stop_q;
			rd_d[`DSMGC_CFG_FRZ_HI:`DSMGC_CFG_FRZ_LO] = freeze_select_q;
			rd_d[`DSMGC_CFG_ARBITRATION_NUMBER_HI:0] = arbitration_number_q;
		end
		else if (stop_q)
			rd_d = 16'h0000;
		else if (reg_addr == `DSMGC_IDX_LVL_VEC)
		begin
			rd_d[`DSMGC_LVL_SYNC_HI:`DSMGC_LVL_SYNC_LO] = sync_irq_level_q;
			rd_d[`DSMGC_LVL_ASYNC_HI:`DSMGC_LVL_ASYNC_LO] =
				async_irq_level_q;
			rd_d[7:0] = {vector_field_q, 1'b1};
		end
		else if (reg_addr == `DSMGC_IDX_PORT_DATA)
			rd_d[7:0] = pin_in;
		else if (reg_addr == `DSMGC_IDX_PAR_DDR)
			rd_d = {pin_assignment_q, pin_direction_q};
	end

	// registered read port, zero when no read
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
			reg_rdata_q <= 16'h0000;
		else
			reg_rdata_q <= reg_rd ? rd_d : 16'h0000;
	end

	// clock gate and freeze halt request
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			module_clk_en_q <= 1'b0;
			sync_halt_req_q <= 1'b0;
		end
		else
		begin
			module_clk_en_q <= ~stop_q;
			// engine itself waits for its transfer boundary
			sync_halt_req_q <= freeze & freeze_select_q[1];
		end
	end

	// pending requests follow flag and enable as levels
	assign sync_pend  = sync_irq_flag & sync_irq_en &
		(sync_irq_level_q != 3'h0);
	assign async_pend = async_irq_flag & async_irq_en &
		(async_irq_level_q != 3'h0);

	// request lines, one per programmed level
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
			irq_lines_q <= 7'h00;
		else
			irq_lines_q <= (sync_pend ? lvl_onehot(sync_irq_level_q)
				: 7'h00) | (async_pend ?
				lvl_onehot(async_irq_level_q) : 7'h00);
	end

	// match against acknowledged level; a zero number never contends
	assign sync_match  = sync_pend & (sync_irq_level_q == iack_level);
	assign async_match = async_pend & (async_irq_level_q == iack_level);
	assign contend     = (sync_match | async_match) &
		(arbitration_number_q != 4'h0);
	// another contender drives a one where we drive a zero
	assign lost        = arb_bus & ~arb_bit_q;

	// acknowledge: serial contention msb first, then vector
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			state_q    <= ST_IDLE;
			bit_idx_q  <= 2'h0;
			src_sync_q <= 1'b0;
			arb_bit_q  <= 1'b0;
			vec_data_q <= 8'h00;
			vec_oe_q   <= 1'b0;
		end
		else
		begin
			case (state_q)
			ST_IDLE:
			begin
				vec_oe_q <= 1'b0;
				if (iack_start && contend)
				begin
					state_q    <= ST_ARB;
					bit_idx_q  <= 2'h3;
					src_sync_q <= sync_match;
					arb_bit_q  <= arbitration_number_q[3];
				end
			end
			ST_ARB:
			begin
				if (lost)
				begin
					state_q   <= ST_IDLE;
					arb_bit_q <= 1'b0;
				end
				else if (bit_idx_q == 2'h0)
				begin
					state_q    <= ST_VEC;
					arb_bit_q  <= 1'b0;
					vec_oe_q   <= 1'b1;
					vec_data_q <= {vector_field_q, src_sync_q};
				end
				else
				begin
					bit_idx_q <= bit_idx_q - 2'h1;
					arb_bit_q <=
						arbitration_number_q[bit_idx_q - 2'h1];
				end
			end
			ST_VEC:
			begin
				state_q    <= ST_IDLE;
				vec_oe_q   <= 1'b0;
				vec_data_q <= 8'h00;
			end
			default:
			begin
				state_q   <= ST_IDLE;
				arb_bit_q <= 1'b0;
				vec_oe_q  <= 1'b0;
			end
			endcase
		end
	end

	// pin function selection
	always @*
	begin
		pin_out_d = port_data_q;
		pin_oe_d  = pin_direction_q;
		for (i = 0; i < 7; i = i + 1)
		begin
			if (pin_assignment_q[i])
				pin_out_d[i] = sync_out[i];
		end
		// clock pin ignores its assignment bit; engine enable alone picks its function
		if (sync_engine_enable)
		begin
			pin_out_d[`DSMGC_PIN_SCK] = sync_out[`DSMGC_PIN_SCK];
			pin_oe_d[`DSMGC_PIN_SCK]  = sync_master;
		end
		else
		begin
			pin_out_d[`DSMGC_PIN_SCK] = port_data_q[`DSMGC_PIN_SCK];
			pin_oe_d[`DSMGC_PIN_SCK] =
				pin_direction_q[`DSMGC_PIN_SCK];
		end
		// select pin assigned to the engine never drives in slave mode
		if (pin_assignment_q[`DSMGC_PIN_SEL] && !sync_master)
			pin_oe_d[`DSMGC_PIN_SEL] = 1'b0;
		// transmit pin belongs to the transmitter while enabled
		if (transmitter_enable)
		begin
			pin_out_d[`DSMGC_PIN_TXD] = tx_data;
			pin_oe_d[`DSMGC_PIN_TXD]  = 1'b1;
		end
	end

	// select pin input meaning, active low on the pin
	always @*
	begin
		mode_fault_d     = 1'b0;
		slave_select_n_d = 1'b1;
		if (pin_assignment_q[`DSMGC_PIN_SEL] &&
			!pin_direction_q[`DSMGC_PIN_SEL])
		begin
			if (sync_master)
				mode_fault_d = sync_engine_enable &
					~pin_in[`DSMGC_PIN_SEL];
			else
				slave_select_n_d = pin_in[`DSMGC_PIN_SEL];
		end
	end

	// pin outputs registered; one cycle behind the registers
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			pin_out_q        <= {NUM_PINS{1'b0}};
			pin_oe_q         <= {NUM_PINS{1'b0}};
			pin_level_q      <= {NUM_PINS{1'b0}};
			mode_fault_q     <= 1'b0;
			slave_select_n_q <= 1'b1;
		end
		else
		begin
			pin_out_q        <= pin_out_d;
			pin_oe_q         <= pin_oe_d;
			pin_level_q      <= pin_in;
			mode_fault_q     <= mode_fault_d;
			slave_select_n_q <= slave_select_n_d;
		end
	end

endmodule

// ==== verification/dsmgc_checker_assertions.sv ====
`timescale 1ns/1ns
module dsmgc_checker #(
	parameter NUM_PINS = 8
) (
	// clock and reset
	input wire                core_clk,
	input wire                reset,
	// register port
	input wire [2:0]          reg_addr,
	input wire                reg_wr,
	input wire                reg_rd,
	input wire [1:0]          reg_byte_en,
	input wire [15:0]         reg_wdata,
	input wire [15:0]         reg_rdata_q,
	// control and interrupts
	input wire                freeze,
	input wire                module_clk_en_q,
	input wire                sync_halt_req_q,
	input wire                sync_irq_flag,
	input wire                async_irq_flag,
	input wire [7:1]          irq_lines_q,
	input wire                vec_oe_q,
	// pins
	input wire                sync_engine_enable,
	input wire                sync_master,
	input wire                transmitter_enable,
	input wire                tx_data,
	input wire                mode_fault_q,
	input wire [NUM_PINS-1:0] pin_out_q,
	input wire [NUM_PINS-1:0] pin_oe_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// gate follows a stop write two edges on
	stop_gate_a:
	assert property (reg_wr && reg_addr == 3'h0 && reg_byte_en[1]
		&& reg_wdata[15] |-> ##2 !module_clk_en_q) else $error("gate open");
	stop_reset_a:
	assert property ($fell(reset) |-> !module_clk_en_q ##1 !module_clk_en_q)
		else $error("not stopped after reset");
	unmapped_read_a:
	assert property ($past(reg_rd && reg_addr == 3'h1) |-> reg_rdata_q == 16'h0)
		else $error("unmapped read not zero");
	halt_freeze_a:
	assert property (!$past(freeze) |-> !sync_halt_req_q)
		else $error("halt without freeze");
	vec_pulse_a:
	assert property (vec_oe_q |=> !vec_oe_q) else $error("vector held");
	irq_quiet_a:
	assert property (!sync_irq_flag && !async_irq_flag && !$past(sync_irq_flag)
		&& !$past(async_irq_flag) |-> irq_lines_q == 7'h0)
		else $error("request without flag");
	tx_pin_a:
	assert property ($past(transmitter_enable) |-> pin_oe_q[7]
		&& pin_out_q[7] == $past(tx_data)) else $error("transmit pin");
	sck_pin_a:
	assert property ($past(sync_engine_enable) |-> pin_oe_q[2]
		== $past(sync_master)) else $error("clock pin direction");
	mode_fault_a:
	assert property (!$past(sync_engine_enable) |-> !mode_fault_q)
		else $error("fault while engine off");
endmodule

bind dsmgc_global_ctrl dsmgc_checker #(.NUM_PINS(NUM_PINS)) i_chk (.*);

// ==== verification/dsmgc_host_model.sv ====
`timescale 1ns/1ns
module dsmgc_host_model (
	// clock
	input  wire        core_clk,
	// register port
	output reg  [2:0]  reg_addr,
	output reg         reg_wr,
	output reg         reg_rd,
	output reg  [1:0]  reg_byte_en,
	output reg  [15:0] reg_wdata,
	input  wire [15:0] reg_rdata_q,
	// acknowledge and contention
	output reg         iack_start,
	output reg  [2:0]  iack_level,
	input  wire        arb_bit_q,
	output wire        arb_bus
);
	reg rival_on;

	// rival contender sends all ones, so it outbids any number below 15
	assign arb_bus = arb_bit_q | rival_on;

	initial
	begin
		{reg_addr, reg_wr, reg_rd, reg_wdata, iack_start, iack_level} = 0;
		reg_byte_en = 2'h3;
		rival_on = 1'b0;
	end

	// strobe held for exactly one sampling edge
	task wr(input [2:0] a, input [15:0] d);
	begin
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	end
	endtask

	task rd(input [2:0] a, output [15:0] q);
	begin
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		q = reg_rdata_q;
	end
	endtask

	task ack(input [2:0] l);
	begin
		@(posedge core_clk);
		iack_start <= 1'b1;
		iack_level <= l;
		@(posedge core_clk);
		iack_start <= 1'b0;
	end
	endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
module testbench;
	// stimulus
	reg         core_clk, reset, freeze, sync_master, tx_data;
	reg         sync_irq_flag, sync_irq_en, async_irq_flag, async_irq_en;
	reg         sync_engine_enable, transmitter_enable;
	reg  [6:0]  sync_out;
	reg  [7:0]  pin_in;
	// bus and results
	wire [2:0]  reg_addr, iack_level;
	wire [1:0]  reg_byte_en;
	wire [15:0] reg_wdata, reg_rdata_q;
	wire        reg_wr, reg_rd, iack_start, arb_bus, arb_bit_q, vec_oe_q;
	wire        module_clk_en_q, sync_halt_req_q, mode_fault_q;
	wire        slave_select_n_q;
	wire [7:1]  irq_lines_q;
	wire [7:0]  vec_data_q, pin_out_q, pin_oe_q, pin_level_q;
	integer     errors, check_count, i;
	reg  [15:0] d, ones;
	reg  [7:0]  v;
	reg         hit;
	reg  [34:0] rows [0:4];

	dsmgc_global_ctrl i_dsmgc_global_ctrl (.*);
	dsmgc_host_model i_dsmgc_host_model (.*);

	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task chk(input [15:0] g, input [15:0] e);
	begin
		check_count = check_count + 1;
		if (g !== e)
		begin
			errors = errors + 1;
			$display("wrong value at %0t got %h exp %h", $time, g, e);
		end
	end
	endtask

	task settle(input integer n);
	begin
		repeat (n) @(posedge core_clk);
		#1;
	end
	endtask

	task test_done;
	begin
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask

	// bounded watch for the one-cycle vector pulse
	task ack_vec(input [2:0] l, input want, input [7:0] ev);
	begin
		hit = 1'b0;
		ones = 16'h0000;
		i_dsmgc_host_model.ack(l);
		repeat (10)
		begin
			settle(1);
			// count the one bits we put out during contention
			if (arb_bit_q === 1'b1)
				ones = ones + 16'h0001;
			if (vec_oe_q === 1'b1)
			begin
				hit = 1'b1;
				v = vec_data_q;
			end
		end
		chk(hit, want);
		// number 5: zero msb, then one, zero, one; a loser drops out at once
		chk(ones, want ? 16'h0002 : 16'h0000);
		if (want)
			chk(v, ev);
		if (want && !hit)
			test_done;
	end
	endtask

	initial
	begin
		{errors, check_count} = 0;
		{reset, sync_master} = 2'b11;
		{freeze, tx_data, sync_out, pin_in} = 0;
		{sync_irq_flag, sync_irq_en, async_irq_flag, async_irq_en} = 0;
		{sync_engine_enable, transmitter_enable} = 0;
		rows[0] = {3'h2, 16'hff42, 16'h3f43};
		rows[1] = {3'h1, 16'hffff, 16'h0000};
		rows[2] = {3'h4, 16'ha5c3, 16'ha5c3};
		rows[3] = {3'h0, 16'h7ff5, 16'h6005};
		rows[4] = {3'h0, 16'h0005, 16'h0005};
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		i_dsmgc_host_model.wr(3'h0, 16'h0005);
		for (i = 0; i < 5; i = i + 1)
		begin
			i_dsmgc_host_model.wr(rows[i][34:32], rows[i][31:16]);
			i_dsmgc_host_model.rd(rows[i][34:32], d);
			chk(d, rows[i][15:0]);
		end
		// upper byte masked off: only the direction byte moves
		i_dsmgc_host_model.reg_byte_en <= 2'h1;
		i_dsmgc_host_model.wr(3'h4, 16'hffff);
		i_dsmgc_host_model.reg_byte_en <= 2'h3;
		i_dsmgc_host_model.rd(3'h4, d);
		chk(d, 16'ha5ff);
		$display("register rows done");
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		settle(1);
		chk(module_clk_en_q, 0);
		i_dsmgc_host_model.rd(3'h0, d);
		chk(d, 16'h8000);
		i_dsmgc_host_model.rd(3'h2, d);
		chk(d, 16'h0000);
		i_dsmgc_host_model.wr(3'h4, 16'h1234);
		i_dsmgc_host_model.wr(3'h0, 16'h0005);
		i_dsmgc_host_model.rd(3'h2, d);
		chk(d, 16'h000f);
		i_dsmgc_host_model.rd(3'h4, d);
		chk(d, 16'h1234);
		chk(module_clk_en_q, 1);
		$display("reset and stop done");
		i_dsmgc_host_model.wr(3'h2, 16'h2d42);
		@(posedge core_clk);
		{sync_irq_flag, sync_irq_en, async_irq_flag, async_irq_en} <= 4'hf;
		settle(2);
		chk(irq_lines_q, 7'h10);
		ack_vec(3'h5, 1'b1, 8'h43);
		ack_vec(3'h3, 1'b0, 8'h00);
		i_dsmgc_host_model.rival_on = 1'b1;
		ack_vec(3'h5, 1'b0, 8'h00);
		i_dsmgc_host_model.rival_on = 1'b0;
		@(posedge core_clk);
		sync_irq_flag <= 1'b0;
		settle(2);
		ack_vec(3'h5, 1'b1, 8'h42);
		i_dsmgc_host_model.wr(3'h2, 16'h2842);
		settle(2);
		chk(irq_lines_q, 7'h00);
		$display("interrupt test done");
		// data first, directions after, so no stale level is driven
		i_dsmgc_host_model.wr(3'h3, 16'h00a5);
		i_dsmgc_host_model.wr(3'h4, 16'h00ff);
		@(posedge core_clk);
		{pin_in, sync_out} <= {8'h34, 7'h00};
		settle(2);
		chk(pin_out_q, 8'ha5);
		chk(pin_oe_q, 8'hff);
		chk(pin_level_q, 8'h34);
		i_dsmgc_host_model.rd(3'h3, d);
		chk(d, 16'h0034);
		i_dsmgc_host_model.wr(3'h4, 16'h0c00);
		@(posedge core_clk);
		{transmitter_enable, tx_data, sync_engine_enable} <= 3'b101;
		settle(2);
		chk(pin_oe_q, 8'h84);
		chk(pin_out_q, 8'h21);
		chk(mode_fault_q, 1);
		@(posedge core_clk);
		sync_master <= 1'b0;
		settle(2);
		chk(slave_select_n_q, 0);
		chk(pin_oe_q, 8'h80);
		$display("pin test done");
		i_dsmgc_host_model.wr(3'h0, 16'h4005);
		@(posedge core_clk);
		freeze <= 1'b1;
		settle(2);
		chk(sync_halt_req_q, 1);
		i_dsmgc_host_model.wr(3'h0, 16'h2005);
		settle(2);
		chk(sync_halt_req_q, 0);
		// quiesce requests and the transmitter before stopping
		@(posedge core_clk);
		{sync_irq_en, async_irq_en, transmitter_enable} <= 3'b000;
		i_dsmgc_host_model.wr(3'h0, 16'h8005);
		settle(2);
		chk(module_clk_en_q, 0);
		$display("freeze and stop done");
		test_done;
	end
endmodule
